// ---- core/rvmr_regs.sv ----
// module: three-register bank for auxiliary regulator codes and buck mode/disable
`timescale 1ns/1ps
`default_nettype none
module rvmr_regs #(
  parameter logic [7:0] RST_AUX_ONE   = rvmr_pkg::RST_AUX_ONE,   // factory default
  parameter logic [7:0] RST_AUX_TWO   = rvmr_pkg::RST_AUX_TWO,   // factory default
  parameter logic [7:0] RST_BUCK_CTRL = rvmr_pkg::RST_BUCK_CTRL  // factory default
) (
  input  wire logic       clock,                     // 100 MHz clock
  input  wire logic       arst_n,                    // async reset, active low
  input  wire logic       wr_en,                     // one-cycle write strobe
  input  wire logic [7:0] wr_addr,                   // write register address
  input  wire logic [7:0] wr_data,                   // write data
  input  wire logic [7:0] rd_addr,                   // read register address
  output logic      [7:0] rd_data,                   // read data, registered
  input  wire logic [2:0] step_down_pin_en,          // enables decoded from control pins
  output logic      [3:0] aux_one_sleep_code,        // aux regulator one sleep code
  output logic      [3:0] aux_one_normal_code,       // aux regulator one normal code
  output logic      [3:0] aux_two_sleep_code,        // aux regulator two sleep code
  output logic      [3:0] aux_two_normal_code,       // aux regulator two normal code
  output logic            step_down_one_mode_sel,    // 1 forced pwm, 0 auto
  output logic            step_down_two_mode_sel,    // 1 forced pwm, 0 auto
  output logic            step_down_three_mode_sel,  // 1 forced pwm, 0 auto
  output logic [2:0]      step_down_run              // final enable per buck
);
  logic [7:0] aux_one_r;
  logic [7:0] aux_two_r;
  logic [5:0] buck_r;
  logic [7:0] buck_rd;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s3_r;
  logic [2:0] pin_ok_r;
  logic [2:0] pin_ok_nxt;
  logic [5:0] buck_nxt;
  logic [2:0] run_r;
  logic [7:0] rd_data_r;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // write strobe aimed at one register address
  function automatic logic addr_hit(input logic       en,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    return en && (addr == target);
  endfunction

  // upper nibble of a voltage register, the sleep code
  function automatic logic [3:0] sleep_field(input logic [7:0] value);
    return value[rvmr_pkg::SLEEP_HI:rvmr_pkg::SLEEP_LO];
  endfunction

  // lower nibble of a voltage register, the normal code
  function automatic logic [3:0] normal_field(input logic [7:0] value);
    return value[rvmr_pkg::NORMAL_HI:rvmr_pkg::NORMAL_LO];
  endfunction

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  // aux one codes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aux_one_r <= RST_AUX_ONE;
    end else if (addr_hit(wr_en, wr_addr, rvmr_pkg::ADDR_AUX_ONE)) begin
      aux_one_r <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aux_two_r <= RST_AUX_TWO;
    end else if (addr_hit(wr_en, wr_addr, rvmr_pkg::ADDR_AUX_TWO)) begin
      aux_two_r <= wr_data;
    end
  end

  always_comb begin
    buck_nxt = buck_r;
    if (addr_hit(wr_en, wr_addr, rvmr_pkg::ADDR_BUCK_CTRL)) begin
      buck_nxt = wr_data[5:0];
    end
  end

  // buck control register, reserved bits never reach a flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      buck_r <= RST_BUCK_CTRL[5:0];
    end else begin
      buck_r <= buck_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  // reserved bits read zero
  assign buck_rd = {2'h0, buck_r} & rvmr_pkg::BUCK_WR_MASK;

  // read data lands one edge after the address; unmapped addresses read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      case (rd_addr)
        rvmr_pkg::ADDR_AUX_ONE:   rd_data_r <= aux_one_r;
        rvmr_pkg::ADDR_AUX_TWO:   rd_data_r <= aux_two_r;
        rvmr_pkg::ADDR_BUCK_CTRL: rd_data_r <= buck_rd;
        default:                  rd_data_r <= 8'h00;
      endcase
    end
  end

  assign rd_data = rd_data_r;

  // ---------------------------------------------------------------------------
  // field outputs
  // ---------------------------------------------------------------------------
  // aux one sleep
  assign aux_one_sleep_code  = sleep_field(aux_one_r);
  assign aux_one_normal_code = normal_field(aux_one_r);
  assign aux_two_sleep_code  = sleep_field(aux_two_r);
  assign aux_two_normal_code = normal_field(aux_two_r);
  assign step_down_three_mode_sel = buck_r[rvmr_pkg::MODE_THREE_BIT];
  assign step_down_two_mode_sel   = buck_r[rvmr_pkg::MODE_TWO_BIT];
  assign step_down_one_mode_sel   = buck_r[rvmr_pkg::MODE_ONE_BIT];

  // ---------------------------------------------------------------------------
  // control pin sync and disable override
  // ---------------------------------------------------------------------------
  // three-stage sync; change accepted when stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_ok_r <= 3'h0;
    end else begin
      pin_s1_r <= step_down_pin_en;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_ok_r <= pin_ok_nxt;
    end
  end

  // accepted level rises when stages two and three show high, falls when both low
  assign pin_ok_nxt = (pin_s2_r & pin_s3_r) | (pin_ok_r & (pin_s2_r | pin_s3_r));

  // fed from next values, so a written zero stops the buck on the next edge
  // disable overrides pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 3'h0;
    end else begin
      run_r <= pin_ok_nxt & buck_nxt[2:0];
    end
  end

  assign step_down_run = run_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_buck_wr;
    wr_en && wr_addr == rvmr_pkg::ADDR_BUCK_CTRL;
  endsequence

  property p_aux_one;
    @(posedge clock) disable iff (!arst_n)
    wr_en && wr_addr == rvmr_pkg::ADDR_AUX_ONE |=> aux_one_normal_code == $past(wr_data[3:0])
      && aux_one_sleep_code == $past(wr_data[7:4]);
  endproperty
  a_aux_one: assert property (p_aux_one) else $error("aux one codes wrong");

  property p_aux_two;
    @(posedge clock) disable iff (!arst_n)
    wr_en && wr_addr == rvmr_pkg::ADDR_AUX_TWO |=> aux_two_normal_code == $past(wr_data[3:0])
      && aux_two_sleep_code == $past(wr_data[7:4]);
  endproperty
  a_aux_two: assert property (p_aux_two) else $error("aux two codes wrong");

  property p_mode;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr |=> {step_down_three_mode_sel, step_down_two_mode_sel, step_down_one_mode_sel}
      == $past(wr_data[5:3]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode select wrong");

  property p_off_three;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##0 !wr_data[2] |=> !step_down_run[2];
  endproperty
  a_off_three: assert property (p_off_three) else $error("buck three not off");

  property p_off_two;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##0 !wr_data[1] |=> !step_down_run[1];
  endproperty
  a_off_two: assert property (p_off_two) else $error("buck two not off");

  property p_off_one;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##0 !wr_data[0] |=> !step_down_run[0];
  endproperty
  a_off_one: assert property (p_off_one) else $error("buck one not off");

  property p_rsvd;
    @(posedge clock) disable iff (!arst_n)
    rd_addr == rvmr_pkg::ADDR_BUCK_CTRL |=> rd_data[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  // pin held through all three sync stages and the run flop
  sequence s_one_pin_on;
    (arst_n && step_down_pin_en[0] && buck_r[0]) [*5];
  endsequence

  property p_pin_run;
    @(posedge clock) disable iff (!arst_n)
    s_one_pin_on |-> step_down_run[0];
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("buck one not enabled by pin");

  property p_readback;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##1 rd_addr == rvmr_pkg::ADDR_BUCK_CTRL
      |=> rd_data == {2'h0, $past(wr_data[5:0], 2)};
  endproperty
  a_readback: assert property (p_readback) else $error("buck readback wrong");

  // a one in a mode bit selects forced pwm, a zero automatic mode
  property p_mode_fpwm;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##0 wr_data[rvmr_pkg::MODE_ONE_BIT]
      |=> step_down_one_mode_sel == rvmr_pkg::MODE_FPWM;
  endproperty
  a_mode_fpwm: assert property (p_mode_fpwm) else $error("buck one not forced pwm");

  property p_mode_auto;
    @(posedge clock) disable iff (!arst_n)
    s_buck_wr ##0 !wr_data[rvmr_pkg::MODE_THREE_BIT]
      |=> step_down_three_mode_sel == rvmr_pkg::MODE_AUTO;
  endproperty
  a_mode_auto: assert property (p_mode_auto) else $error("buck three not automatic");

  // a stored zero keeps the buck off whatever the pins do
  property p_keep_three;
    @(posedge clock) disable iff (!arst_n)
    !buck_r[rvmr_pkg::OFF_THREE_BIT] |-> !step_down_run[2];
  endproperty
  a_keep_three: assert property (p_keep_three) else $error("buck three on while off");

  property p_keep_two;
    @(posedge clock) disable iff (!arst_n)
    !buck_r[rvmr_pkg::OFF_TWO_BIT] |-> !step_down_run[1];
  endproperty
  a_keep_two: assert property (p_keep_two) else $error("buck two on while off");

  property p_keep_one;
    @(posedge clock) disable iff (!arst_n)
    !buck_r[rvmr_pkg::OFF_ONE_BIT] |-> !step_down_run[0];
  endproperty
  a_keep_one: assert property (p_keep_one) else $error("buck one on while off");

  // a pin held low through the whole sync depth leaves buck one off
  property p_pin_drop;
    @(posedge clock) disable iff (!arst_n)
    (!step_down_pin_en[0]) [*5] |-> !step_down_run[0];
  endproperty
  a_pin_drop: assert property (p_pin_drop) else $error("buck one on without pin");

  // codes hold between writes to their own register
  property p_hold_aux_one;
    @(posedge clock) disable iff (!arst_n)
    !(wr_en && wr_addr == rvmr_pkg::ADDR_AUX_ONE)
      |=> $stable({aux_one_sleep_code, aux_one_normal_code});
  endproperty
  a_hold_aux_one: assert property (p_hold_aux_one) else $error("aux one drift");

  // codes hold between writes to their own register
  property p_hold_aux_two;
    @(posedge clock) disable iff (!arst_n)
    !(wr_en && wr_addr == rvmr_pkg::ADDR_AUX_TWO)
      |=> $stable({aux_two_sleep_code, aux_two_normal_code});
  endproperty
  a_hold_aux_two: assert property (p_hold_aux_two) else $error("aux two drift");

  // mode selects hold between buck control writes
  property p_hold_buck;
    @(posedge clock) disable iff (!arst_n)
    !(wr_en && wr_addr == rvmr_pkg::ADDR_BUCK_CTRL)
      |=> $stable({step_down_three_mode_sel, step_down_two_mode_sel, step_down_one_mode_sel});
  endproperty
  a_hold_buck: assert property (p_hold_buck) else $error("mode select drift");

  // read data carries both codes of aux one
  property p_rd_aux_one;
    @(posedge clock) disable iff (!arst_n)
    arst_n && rd_addr == rvmr_pkg::ADDR_AUX_ONE
      |=> rd_data == {$past(aux_one_sleep_code), $past(aux_one_normal_code)};
  endproperty
  a_rd_aux_one: assert property (p_rd_aux_one) else $error("aux one readback");

  // read data carries both codes of aux two
  property p_rd_aux_two;
    @(posedge clock) disable iff (!arst_n)
    arst_n && rd_addr == rvmr_pkg::ADDR_AUX_TWO
      |=> rd_data == {$past(aux_two_sleep_code), $past(aux_two_normal_code)};
  endproperty
  a_rd_aux_two: assert property (p_rd_aux_two) else $error("aux two readback");
endmodule
`default_nettype wire

// ---- core/rvmr_pkg.sv ----
// package: register offsets, field positions and reset defaults of the regulator mode bank
// ---------------------------------------------------------------------------
// Operation
// - Bits 7:4 of the first auxiliary regulator voltage register hold its sleep code, read-write.
// - Bits 3:0 of the first auxiliary regulator voltage register hold its normal code, read-write.
// - Bits 7:4 of the second auxiliary regulator voltage register hold its sleep code, read-write.
// - Bits 3:0 of the second auxiliary regulator voltage register hold its normal code, read-write.
// - Buck control bits 5, 4 and 3 are the mode selects of step-down three, two and one.
// - A mode bit at 0 selects automatic mode and at 1 selects forced PWM.
// - Buck control bit 2 at 0 turns step-down three off whatever the control pins show.
// - Buck control bit 1 at 0 turns step-down two off whatever the control pins show.
// - Buck control bit 0 at 0 turns step-down one off whatever the control pins show.
// ---------------------------------------------------------------------------
package rvmr_pkg;
  localparam logic [7:0] ADDR_AUX_ONE   = 8'h9a;
  localparam logic [7:0] ADDR_AUX_TWO   = 8'h9b;
  localparam logic [7:0] ADDR_BUCK_CTRL = 8'h9c;
  localparam int SLEEP_HI  = 7;
  localparam int SLEEP_LO  = 4;
  localparam int NORMAL_HI = 3;
  localparam int NORMAL_LO = 0;
  localparam int MODE_THREE_BIT = 5;
  localparam int MODE_TWO_BIT   = 4;
  localparam int MODE_ONE_BIT   = 3;
  localparam int OFF_THREE_BIT  = 2;
  localparam int OFF_TWO_BIT    = 1;
  localparam int OFF_ONE_BIT    = 0;
  localparam logic [7:0] BUCK_WR_MASK = 8'h3f;
  // reset values are factory programmed; these are plain defaults
  localparam logic [7:0] RST_AUX_ONE   = 8'h00;
  localparam logic [7:0] RST_AUX_TWO   = 8'h00;
  localparam logic [7:0] RST_BUCK_CTRL = 8'h07;
  localparam logic       MODE_AUTO     = 1'b0;
  localparam logic       MODE_FPWM     = 1'b1;
endpackage

// ---- testbench/rvmr_host.sv ----
// host model: drives register writes and reads into the regulator mode bank
`timescale 1ns/1ps
`default_nettype none
module rvmr_host (
  input  wire logic       clock,    // bank clock
  output logic            wr_en,    // write strobe
  output logic      [7:0] wr_addr,  // write address
  output logic      [7:0] wr_data,  // write data
  output logic      [7:0] rd_addr,  // read address
  input  wire logic [7:0] rd_data   // read data from bank
);
  // idle bus values at time zero
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end
  // one-cycle write; released lines show the inverse so stale data never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en   <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  // read: present the address, sample once settled after the next edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_addr <= a;
    @(posedge clock);
    #1 d = rd_data;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_regulator_voltage_mode_regs.sv ----
// testbench: random and corner register traffic against the regulator mode bank
`timescale 1ns/1ps
`default_nettype none
module test_regulator_voltage_mode_regs;
  localparam logic [15:0] CORNER [5] = '{16'h9cff, 16'h9c00, 16'h9aff, 16'h9b5a, 16'h77ff};
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] pins = 3'h7;
  logic       wr_en, m1, m2, m3;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, got, a, d;
  logic [3:0] s1, n1, s2, n2;
  logic [2:0] run;
  logic [7:0] exp [3];
  int         err_count = 0;
  int         checks = 0;
  int         seed = 81363;

  always #5 clock = ~clock;

  rvmr_regs i_rvmr_regs (.clock(clock), .arst_n(arst_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .step_down_pin_en(pins),
    .aux_one_sleep_code(s1), .aux_one_normal_code(n1), .aux_two_sleep_code(s2),
    .aux_two_normal_code(n2), .step_down_one_mode_sel(m1), .step_down_two_mode_sel(m2),
    .step_down_three_mode_sel(m3), .step_down_run(run));
  rvmr_host i_rvmr_host (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));

  // expected read value per address, unmapped reads zero
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    case (ad)
      8'h9a:   return exp[0];
      8'h9b:   return exp[1];
      8'h9c:   return exp[2];
      default: return 8'h00;
    endcase
  endfunction
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // verdict and end of run
  task automatic results;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reset for five cycles, then read back the defaults
  task automatic rst_seq;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    exp = '{rvmr_pkg::RST_AUX_ONE, rvmr_pkg::RST_AUX_TWO,
            rvmr_pkg::RST_BUCK_CTRL & rvmr_pkg::BUCK_WR_MASK};
    for (int k = 0; k < 3; k++) begin
      i_rvmr_host.read(8'h9a + 8'(k), got);
      chk(got, exp[k]);
    end
  endtask

  // main sequence: corners first, then random traffic with random pin enables
  initial begin
    rst_seq();
    for (int i = 0; i < 45; i++) begin
      @(posedge clock);
      pins <= 3'($random(seed));
      if (i < 5) {a, d} = CORNER[i];
      else begin
        a = 8'h9a + 8'($unsigned($random(seed)) % 4);
        d = 8'($random(seed));
      end
      i_rvmr_host.write(a, d);
      if (a == 8'h9a) exp[0] = d;
      else if (a == 8'h9b) exp[1] = d;
      else if (a == 8'h9c) exp[2] = d & rvmr_pkg::BUCK_WR_MASK;
      i_rvmr_host.read(a, got);
      chk(got, exp_rd(a));
      chk({s1, n1}, exp[0]);
      chk({s2, n2}, exp[1]);
      chk({5'h00, m3, m2, m1}, {5'h00, exp[2][5:3]});
      repeat (3) @(posedge clock);
      #1 chk({5'h00, run}, {5'h00, pins & exp[2][2:0]});
    end
    rst_seq();
    results();
  end
  // watchdog against a hung run
  initial begin
    #50000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
